/* rtl/ptd_defines.vh */
// Purpose: Constants of the packet test and diagnostic block
// Assumes: Paged register port, 16-bit registers
// Notes:   Included by the packet test module only; the counter does not use it
`ifndef PTD_DEFINES_VH
`define PTD_DEFINES_VH

// ----------------------------------------------------------------
// Register locations
// ----------------------------------------------------------------
`define PTD_SPACE_PAGED     1'h0
`define PTD_SPACE_EXT       1'h1
`define PTD_PAGE_PAIR       6'h05
`define PTD_PAGE_TEST       6'h06
`define PTD_DEV_PCS         5'h03
`define PTD_REG_SKEW        16'h0014
`define PTD_REG_PAIR        16'h0015
`define PTD_REG_GEN         16'h0010
`define PTD_REG_CNT         16'h0011
`define PTD_REG_CHK         16'h0012
`define PTD_REG_MISC        16'h001a
`define PTD_REG_PCS         16'h0000

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PTD_PAIR_VALID      6
`define PTD_PAIR_CD         5
`define PTD_PAIR_AB         4
`define PTD_GEN_BURST       15:8
`define PTD_GEN_CHKEN       4
`define PTD_GEN_EN          3
`define PTD_GEN_PAYLOAD     2
`define PTD_GEN_LEN         1
`define PTD_GEN_ERR         0
`define PTD_GEN_MASK        16'hff1f
`define PTD_CHK_CLR         4
`define PTD_CHK_STUB        3
`define PTD_CHK_MASK        16'hffef
`define PTD_MISC_TCLK       15
`define PTD_MISC_MASK       16'hffa0
`define PTD_PCS_STOP        10

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PTD_RST_REG         16'h0000
`define PTD_RST_MISC        16'h1900

// ----------------------------------------------------------------
// Packet figures
// ----------------------------------------------------------------
`define PTD_LEN_LONG        11'h5ee
`define PTD_LEN_SHORT       11'h040
`define PTD_CRC_BYTES       11'h004
`define PTD_GAP_BYTES       11'h00c
`define PTD_PAT_A           8'h5a
`define PTD_PAT_B           8'ha5
`define PTD_LFSR_SEED       16'hace1
`define PTD_CRC_INIT        32'hffffffff
`define PTD_CRC_POLY        32'hedb88320
`define PTD_CRC_RESIDUE     32'hdebb20e3

`endif

/* rtl/ptd_sat_counter.v */
// Purpose: Saturating event counter with synchronous clear
// Assumes: Single clock, clear dominates increment
// Notes:   Holds at all ones instead of wrapping
`timescale 1ns/10ps
module ptd_sat_counter #(
  parameter WIDTH = 8
) (
  input  wire             clk,
  input  wire             rst,
  input  wire             clear,
  input  wire             inc,
  output reg  [WIDTH-1:0] count_ff
);

  wire [WIDTH-1:0] maxVal = {WIDTH{1'b1}};

  always @(posedge clk) begin
    if (rst || clear) begin
      count_ff <= {WIDTH{1'b0}};
    end else if (inc && (count_ff != maxVal)) begin
      count_ff <= count_ff + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

endmodule // ptd_sat_counter

/* rtl/ptd_packet_test.v */
// Purpose: Pair status, test packet generator and receive CRC checker
// Assumes: Receive and status inputs come from logic on clk
// Notes:   Read data appear one cycle after the read strobe
//
// Overview of operation
// - Bit 6 of pair status flags crossover, polarity and skew results valid.
// - Bit 5 reports channels C and D straight (1) or swapped (0).
// - Bit 4 reports channels A and B straight (1) or swapped (0).
// - Bits 3:0 give per-pair receive polarity, 1 negative, 0 positive.
// - Burst field zero sends continuously, otherwise exactly that many packets.
// - Test packets go out only while the generator enable bit is set.
// - Payload is pseudo-random when bit 2 is 0, else 5A A5 repeating.
// - Length bit selects 1518-byte packets when 1, 64-byte when 0.
// - Error bit sends packets with both CRC error and symbol error.
// - Received packets counted in upper byte, saturating at 0xFF.
// - CRC-failed packets counted in lower byte, saturating at 0xFF.
// - Counters only valid and counting while checker enable bit is set.
// - Writing counter reset zeroes both counters, then the bit self clears.
// - Checker control bit 3 selects stub test operation.
// - Highest enabled port drives its transmit clock to the test pin.
// - PCS control bit 10 tells whether clock may stop in low power idle.
// - Four-bit pair skew fields in 8 ns units, under same valid flag.
`timescale 1ns/10ps
`include "ptd_defines.vh"
module ptd_packet_test (
  input  wire        clk,
  input  wire        rst,
  input  wire        swRst,
  input  wire        regWe,
  input  wire        regRe,
  input  wire        regSpace,
  input  wire [5:0]  regPage,
  input  wire [4:0]  regDev,
  input  wire [15:0] regAddr,
  input  wire [15:0] regWdata,
  output reg  [15:0] regRdata_ff,
  output reg         regRvalid_ff,
  input  wire        pairResultValid,
  input  wire        cdStraight,
  input  wire        abStraight,
  input  wire [3:0]  pairPolarity,
  input  wire [15:0] pairSkew,
  input  wire        rxValid,
  input  wire [7:0]  rxData,
  input  wire        higherPortTclk,
  output reg  [7:0]  txData_ff,
  output reg         txValid_ff,
  output reg         txSymbolError_ff,
  output reg         stubTestEnable_ff,
  output reg         transmitClockTestOutputEnable_ff,
  output reg         differentialTestClockPinDrive_ff,
  output reg         clockStoppable_ff
);

  // ----------------------------------------------------------------
  // Shared CRC step
  // ----------------------------------------------------------------
  function [31:0] crcByte;
    input [31:0] crc;
    input [7:0]  data;
    integer      i;
    reg   [31:0] c;
    begin
      c = crc ^ {24'h000000, data};
      for (i = 0; i < 8; i = i + 1) begin
        c = c[0] ? ((c >> 1) ^ `PTD_CRC_POLY) : (c >> 1);
      end
      crcByte = c;
    end
  endfunction

  localparam ST_IDLE = 2'h0;
  localparam ST_DATA = 2'h1;
  localparam ST_GAP  = 2'h2;
  localparam ST_DONE = 2'h3;

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  reg  [15:0] genReg_ff;
  reg  [15:0] chkReg_ff;
  reg  [15:0] miscReg_ff;
  reg         pcsStop_ff;
  reg         cntClear_ff;
  wire [7:0]  pktCount;
  wire [7:0]  errCount;

  wire pagedHit = (regSpace == `PTD_SPACE_PAGED);
  wire hitGen   = pagedHit && (regPage == `PTD_PAGE_TEST) && (regAddr == `PTD_REG_GEN);
  wire hitCnt   = pagedHit && (regPage == `PTD_PAGE_TEST) && (regAddr == `PTD_REG_CNT);
  wire hitChk   = pagedHit && (regPage == `PTD_PAGE_TEST) && (regAddr == `PTD_REG_CHK);
  wire hitMisc  = pagedHit && (regPage == `PTD_PAGE_TEST) && (regAddr == `PTD_REG_MISC);
  wire hitPair  = pagedHit && (regPage == `PTD_PAGE_PAIR) && (regAddr == `PTD_REG_PAIR);
  wire hitSkew  = pagedHit && (regPage == `PTD_PAGE_PAIR) && (regAddr == `PTD_REG_SKEW);
  wire hitPcs   = (regSpace == `PTD_SPACE_EXT) && (regDev == `PTD_DEV_PCS)
                  && (regAddr == `PTD_REG_PCS);
  wire genWrite = regWe && hitGen;

  // Results are masked while the measurement is not settled
  wire [15:0] pairWord = {9'h000, pairResultValid,
                          pairResultValid ? {cdStraight, abStraight, pairPolarity}
                                          : 6'h00};
  wire [15:0] skewWord = pairResultValid ? pairSkew : `PTD_RST_REG;

  always @(posedge clk) begin
    if (rst) begin
      genReg_ff   <= `PTD_RST_REG;
      chkReg_ff   <= `PTD_RST_REG;
      miscReg_ff  <= `PTD_RST_MISC;
      pcsStop_ff  <= 1'b0;
      cntClear_ff <= 1'b0;
    end else begin
      cntClear_ff <= regWe && hitChk && regWdata[`PTD_CHK_CLR];
      if (swRst) begin
        miscReg_ff[`PTD_MISC_TCLK] <= 1'b0;
      end else if (regWe && hitMisc) begin
        miscReg_ff <= regWdata & `PTD_MISC_MASK;
      end
      if (genWrite) begin
        genReg_ff <= regWdata & `PTD_GEN_MASK;
      end
      if (regWe && hitChk) begin
        chkReg_ff <= regWdata & `PTD_CHK_MASK;
      end
      if (regWe && hitPcs) begin
        pcsStop_ff <= regWdata[`PTD_PCS_STOP];
      end
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      regRdata_ff  <= `PTD_RST_REG;
      regRvalid_ff <= 1'b0;
    end else begin
      regRvalid_ff <= regRe;
      if (regRe) begin
        if (hitPair) begin
          regRdata_ff <= pairWord;
        end else if (hitSkew) begin
          regRdata_ff <= skewWord;
        end else if (hitGen) begin
          regRdata_ff <= genReg_ff;
        end else if (hitCnt) begin
          regRdata_ff <= {pktCount, errCount};
        end else if (hitChk) begin
          regRdata_ff <= chkReg_ff | {11'h000, cntClear_ff, 4'h0};
        end else if (hitMisc) begin
          regRdata_ff <= miscReg_ff;
        end else if (hitPcs) begin
          regRdata_ff <= {5'h00, pcsStop_ff, 10'h000};
        end else begin
          regRdata_ff <= `PTD_RST_REG;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      stubTestEnable_ff                <= 1'b0;
      transmitClockTestOutputEnable_ff <= 1'b0;
      differentialTestClockPinDrive_ff <= 1'b0;
      clockStoppable_ff                <= 1'b0;
    end else begin
      stubTestEnable_ff                <= chkReg_ff[`PTD_CHK_STUB];
      transmitClockTestOutputEnable_ff <= miscReg_ff[`PTD_MISC_TCLK];
      // A higher port claiming the pin takes precedence over this one
      differentialTestClockPinDrive_ff <= miscReg_ff[`PTD_MISC_TCLK]
                                          && !higherPortTclk;
      clockStoppable_ff                <= pcsStop_ff;
    end
  end

  // ----------------------------------------------------------------
  // Packet generator
  // ----------------------------------------------------------------
  reg  [1:0]  state_ff;
  reg  [1:0]  nxt_state;
  reg  [10:0] byteCnt_ff;
  reg  [10:0] nxt_byteCnt;
  reg  [7:0]  sentCnt_ff;
  reg  [7:0]  nxt_sentCnt;
  reg  [31:0] txCrc_ff;
  reg  [31:0] nxt_txCrc;
  reg  [15:0] lfsr_ff;
  reg  [7:0]  nxt_txData;
  reg         nxt_txValid;
  reg         nxt_txErr;
  reg  [7:0]  payByte;
  reg  [1:0]  crcIdx;
  reg  [31:0] crcOut;

  wire        genEn    = genReg_ff[`PTD_GEN_EN];
  wire [7:0]  burst    = genReg_ff[`PTD_GEN_BURST];
  wire [10:0] pktLen   = genReg_ff[`PTD_GEN_LEN] ? `PTD_LEN_LONG : `PTD_LEN_SHORT;
  wire [10:0] payLen   = pktLen - `PTD_CRC_BYTES;
  wire        lastByte = (byteCnt_ff == pktLen - 11'h001);
  wire        lfsrFb   = lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10];

  always @* begin
    nxt_state   = state_ff;
    nxt_byteCnt = byteCnt_ff;
    nxt_sentCnt = sentCnt_ff;
    nxt_txCrc   = txCrc_ff;
    nxt_txData  = 8'h00;
    nxt_txValid = 1'b0;
    nxt_txErr   = 1'b0;
    payByte     = genReg_ff[`PTD_GEN_PAYLOAD]
                  ? (byteCnt_ff[0] ? `PTD_PAT_B : `PTD_PAT_A) : lfsr_ff[7:0];
    crcOut      = ~txCrc_ff;
    crcIdx      = byteCnt_ff[1:0] - payLen[1:0];
    case (state_ff)
      ST_IDLE: begin
        nxt_byteCnt = 11'h000;
        nxt_sentCnt = 8'h00;
        nxt_txCrc   = `PTD_CRC_INIT;
        if (genEn) begin
          nxt_state = ST_DATA;
        end
      end
      ST_DATA: begin
        nxt_txValid = 1'b1;
        nxt_byteCnt = byteCnt_ff + 11'h001;
        if (byteCnt_ff < payLen) begin
          nxt_txData = payByte;
          nxt_txCrc  = crcByte(txCrc_ff, payByte);
        end else begin
          nxt_txData = crcOut[8*crcIdx +: 8];
        end
        if (lastByte) begin
          // Corrupt the check word and flag a symbol error on the same byte
          if (genReg_ff[`PTD_GEN_ERR]) begin
            nxt_txData = ~nxt_txData;
            nxt_txErr  = 1'b1;
          end
          nxt_byteCnt = 11'h000;
          nxt_sentCnt = sentCnt_ff + 8'h01;
          nxt_state   = ST_GAP;
        end
      end
      ST_GAP: begin
        nxt_txCrc   = `PTD_CRC_INIT;
        nxt_byteCnt = byteCnt_ff + 11'h001;
        if (byteCnt_ff == `PTD_GAP_BYTES - 11'h001) begin
          nxt_byteCnt = 11'h000;
          if ((burst != 8'h00) && (sentCnt_ff >= burst)) begin
            nxt_state = ST_DONE;
          end else begin
            nxt_state = ST_DATA;
          end
        end
      end
      ST_DONE: begin
        nxt_sentCnt = sentCnt_ff;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    // Disable aborts at once; a frame in flight is cut short
    if (!genEn) begin
      nxt_state   = ST_IDLE;
      nxt_txValid = 1'b0;
      nxt_txErr   = 1'b0;
      nxt_txData  = 8'h00;
    end else if (genWrite && (state_ff == ST_DONE)) begin
      nxt_state = ST_IDLE;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      state_ff         <= ST_IDLE;
      byteCnt_ff       <= 11'h000;
      sentCnt_ff       <= 8'h00;
      txCrc_ff         <= `PTD_CRC_INIT;
      lfsr_ff          <= `PTD_LFSR_SEED;
      txData_ff        <= 8'h00;
      txValid_ff       <= 1'b0;
      txSymbolError_ff <= 1'b0;
    end else begin
      state_ff         <= nxt_state;
      byteCnt_ff       <= nxt_byteCnt;
      sentCnt_ff       <= nxt_sentCnt;
      txCrc_ff         <= nxt_txCrc;
      txData_ff        <= nxt_txData;
      txValid_ff       <= nxt_txValid;
      txSymbolError_ff <= nxt_txErr;
      if (state_ff == ST_DATA) begin
        lfsr_ff <= {lfsr_ff[14:0], lfsrFb};
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive CRC checker
  // ----------------------------------------------------------------
  reg  [31:0] rxCrc_ff;
  reg         rxValidDly_ff;
  wire        chkEn  = genReg_ff[`PTD_GEN_CHKEN];
  wire        rxEnd  = rxValidDly_ff && !rxValid;
  wire        pktInc = chkEn && rxEnd;
  wire        errInc = pktInc && (rxCrc_ff != `PTD_CRC_RESIDUE);

  always @(posedge clk) begin
    if (rst) begin
      rxCrc_ff      <= `PTD_CRC_INIT;
      rxValidDly_ff <= 1'b0;
    end else begin
      rxValidDly_ff <= rxValid;
      if (rxValid) begin
        rxCrc_ff <= crcByte(rxCrc_ff, rxData);
      end else begin
        rxCrc_ff <= `PTD_CRC_INIT;
      end
    end
  end

  ptd_sat_counter #(
    .WIDTH    (8)
  ) u_pktCounter (
    .clk      (clk),
    .rst      (rst),
    .clear    (cntClear_ff),
    .inc      (pktInc),
    .count_ff (pktCount)
  );

  ptd_sat_counter #(
    .WIDTH    (8)
  ) u_errCounter (
    .clk      (clk),
    .rst      (rst),
    .clear    (cntClear_ff),
    .inc      (errInc),
    .count_ff (errCount)
  );

endmodule // ptd_packet_test

/* sim/ptd_packet_test_sva.sv */
// Purpose: Assertion checker for the packet test block
// Assumes: Bound to ptd_packet_test, single clock
// Notes:   Shadows register writes to know the live settings
`timescale 1ns/10ps
module ptd_packet_test_sva (
  input logic        clk,
  input logic        rst,
  input logic        regWe,
  input logic        regRe,
  input logic        regSpace,
  input logic [5:0]  regPage,
  input logic [4:0]  regDev,
  input logic [15:0] regAddr,
  input logic [15:0] regWdata,
  input logic [15:0] regRdata_ff,
  input logic        regRvalid_ff,
  input logic        pairResultValid,
  input logic        cdStraight,
  input logic        abStraight,
  input logic [3:0]  pairPolarity,
  input logic        higherPortTclk,
  input logic [7:0]  txData_ff,
  input logic        txValid_ff,
  input logic        txSymbolError_ff,
  input logic        stubTestEnable_ff,
  input logic        transmitClockTestOutputEnable_ff,
  input logic        differentialTestClockPinDrive_ff,
  input logic        clockStoppable_ff
);
  logic [15:0] gen_ff;
  logic        stub_ff;
  logic        pcs_ff;
  logic [10:0] runLen_ff;
  wire         p6 = regWe && !regSpace && regPage == 6'h06;
  wire         pairRd = regRe && !regSpace && regPage == 6'h05 && regAddr == 16'h0015;
  // ----------------------------------------------------------------
  // Shadow state
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      gen_ff    <= 16'h0000;
      stub_ff   <= 1'b0;
      pcs_ff    <= 1'b0;
      runLen_ff <= 11'h000;
    end else begin
      if (p6 && regAddr == 16'h0010) gen_ff <= regWdata;
      if (p6 && regAddr == 16'h0012) stub_ff <= regWdata[3];
      if (regWe && regSpace && regDev == 5'h03 && regAddr == 16'h0000) pcs_ff <= regWdata[10];
      runLen_ff <= txValid_ff ? runLen_ff + 11'h001 : 11'h000;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence lastByte;
    txValid_ff ##1 !txValid_ff;
  endsequence
  a_read_answer:
    assert property (regRe |=> regRvalid_ff) else $error("read got no answer");
  a_pair_status:
    assert property (pairRd |=> regRdata_ff[6:0] == ($past(pairResultValid) ?
      {1'b1, $past(cdStraight), $past(abStraight), $past(pairPolarity)} : 7'h00))
      else $error("pair status read wrong");
  a_tx_needs_enable:
    assert property (!gen_ff[3] |=> !txValid_ff) else $error("sending while disabled");
  a_frame_length:
    assert property ($fell(txValid_ff) && gen_ff[3] |->
      runLen_ff == (gen_ff[1] ? 11'h5ee : 11'h040)) else $error("frame length wrong");
  a_payload_pattern:
    assert property (txValid_ff && gen_ff[2] && runLen_ff < (gen_ff[1] ? 11'h5ea : 11'h03c)
      |-> txData_ff == (runLen_ff[0] ? 8'ha5 : 8'h5a)) else $error("payload pattern wrong");
  a_symbol_error:
    assert property (txSymbolError_ff |-> gen_ff[0] ##0 lastByte)
      else $error("symbol error misplaced");
  a_error_marked:
    assert property ($fell(txValid_ff) && gen_ff[0] && gen_ff[3] |-> $past(txSymbolError_ff))
      else $error("errored frame lacks symbol error");
  a_pin_drive:
    assert property (differentialTestClockPinDrive_ff ==
      (transmitClockTestOutputEnable_ff && !$past(higherPortTclk))) else $error("test pin wrong");
  a_stub_follow:
    assert property (stubTestEnable_ff == $past(stub_ff)) else $error("stub output wrong");
  a_lpi_clock:
    assert property (clockStoppable_ff == $past(pcs_ff)) else $error("clock stop bit wrong");
endmodule // ptd_packet_test_sva

bind ptd_packet_test ptd_packet_test_sva ptd_packet_test_sva_i (.*);

/* sim/ptd_rx_source.sv */
// Purpose: Far-side frame source feeding the receive checker
// Assumes: One frame per go pulse, payload then four FCS bytes
// Notes:   Idle data toggles so a stale byte never looks valid
`timescale 1ns/10ps
module ptd_rx_source (
  input  logic       clk,
  input  logic       go,
  input  logic [7:0] nBytes,
  input  logic       bad,
  output logic       rxValid,
  output logic [7:0] rxData,
  output logic       busy
);
  logic [31:0] crc;
  logic [7:0]  b;
  int          i;
  int          k;
  initial begin
    rxValid = 1'b0;
    rxData  = 8'h00;
    busy    = 1'b0;
    forever begin
      @(posedge clk);
      if (go) begin
        busy <= 1'b1;
        crc = 32'hffffffff;
        for (i = 0; i < nBytes + 4; i++) begin
          if (i < nBytes) begin
            b = 8'(i * 29 + 7);
            for (k = 0; k < 8; k++)
              crc = (crc >> 1) ^ ((crc[0] ^ b[k]) ? 32'hedb88320 : 32'h0);
          end else
            b = ~crc[8*(i-nBytes)+:8] ^ {7'h00, bad && i == nBytes + 3};
          rxValid <= 1'b1;
          rxData  <= b;
          @(posedge clk);
        end
        rxValid <= 1'b0;
        busy    <= 1'b0;
      end else
        rxData <= ~rxData;
    end
  end
endmodule // ptd_rx_source

/* sim/ptd_packet_test_bench.sv */
// Purpose: Self-checking bench of the packet test block
// Assumes: 50 MHz clock, synchronous reset held two cycles
// Notes:   Generator output loops back into the checker when loop is set
`timescale 1ns/10ps
module ptd_packet_test_bench;
  logic clk = 1'b0, rst = 1'b1, swRst = 1'b0, regWe = 1'b0, regRe = 1'b0;
  logic regSpace = 1'b0, pairResultValid = 1'b0, cdStraight = 1'b0, abStraight = 1'b0;
  logic higherPortTclk = 1'b0, go = 1'b0, bad = 1'b0, loop = 1'b0, txPrev = 1'b0;
  logic [5:0]  regPage = 6'h00;
  logic [4:0]  regDev = 5'h00;
  logic [15:0] regAddr = 16'h0000, regWdata = 16'h0000, pairSkew = 16'h0000;
  logic [3:0]  pairPolarity = 4'h0;
  logic [7:0]  nb = 8'h00;
  logic [15:0] regRdata_ff;
  logic [7:0]  txData_ff, srcData;
  logic        regRvalid_ff, txValid_ff, txSymbolError_ff, stubTestEnable_ff, srcValid, srcBusy;
  logic        transmitClockTestOutputEnable_ff, differentialTestClockPinDrive_ff;
  logic        clockStoppable_ff, e, p;
  int          error_cnt = 0, n_compared = 0, frames = 0, f0, nBad;
  wire         rxValid = loop ? txValid_ff : srcValid;
  wire [7:0]   rxData = loop ? txData_ff : srcData;
  ptd_packet_test ptd_packet_test_i (.*);
  ptd_rx_source ptd_rx_source_i (.clk(clk), .go(go), .nBytes(nb), .bad(bad),
    .rxValid(srcValid), .rxData(srcData), .busy(srcBusy));
  always #10 clk = ~clk;
  always @(posedge clk) begin
    txPrev <= txValid_ff;
    if (txPrev && !txValid_ff) frames <= frames + 1;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    if (error_cnt == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic sel(input logic sp, input logic [5:0] pg, input logic [15:0] a);
    regSpace <= sp;
    regPage  <= pg;
    regDev   <= 5'h03;
    regAddr  <= a;
  endtask
  task automatic wr(input logic sp, input logic [5:0] pg, input logic [15:0] a, d);
    sel(sp, pg, a);
    regWdata <= d;
    regWe    <= 1'b1;
    @(posedge clk);
    regWe <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic rd(input logic sp, input logic [5:0] pg, input logic [15:0] a, exp);
    sel(sp, pg, a);
    regRe <= 1'b1;
    @(posedge clk);
    regRe <= 1'b0;
    @(posedge clk);
    check(regRdata_ff, exp);
  endtask
  task automatic frame(input logic [7:0] n, input logic b);
    go  <= 1'b1;
    nb  <= n;
    bad <= b;
    @(posedge clk);
    go <= 1'b0;
    repeat (2) @(posedge clk);
    for (int k = 0; k < 600 && srcBusy; k++) @(posedge clk);
    repeat (3) @(posedge clk);
  endtask
  function automatic logic [15:0] pairExp();
    return pairResultValid ? {9'h000, 1'b1, cdStraight, abStraight, pairPolarity} : 16'h0000;
  endfunction
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(9757));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(0, 6'h06, 16'h0010, 16'h0000);
    rd(0, 6'h06, 16'h0011, 16'h0000);
    rd(0, 6'h06, 16'h001a, 16'h1900);
    rd(1, 6'h00, 16'h0000, 16'h0000);
    wr(0, 6'h06, 16'h0013, 16'hffff);
    rd(0, 6'h06, 16'h0013, 16'h0000);
    for (int j = 0; j < 8; j++) begin
      pairResultValid <= j[0];
      {cdStraight, abStraight, pairPolarity} <= 6'($urandom);
      pairSkew <= 16'($urandom);
      @(posedge clk);
      rd(0, 6'h05, 16'h0015, pairExp());
      rd(0, 6'h05, 16'h0014, pairResultValid ? pairSkew : 16'h0000);
    end
    wr(0, 6'h06, 16'h0010, 16'h0010);
    wr(0, 6'h06, 16'h0012, 16'h0010);
    rd(0, 6'h06, 16'h0012, 16'h0000);
    nBad = 0;
    for (int j = 0; j < 6; j++) begin
      e = 1'($urandom);
      nBad += e;
      frame(8'(1 + $urandom % 8), e);
    end
    rd(0, 6'h06, 16'h0011, {8'h06, 8'(nBad)});
    for (int j = 0; j < 256; j++) frame(8'h01, 1'b1);
    rd(0, 6'h06, 16'h0011, 16'hffff);
    wr(0, 6'h06, 16'h0012, 16'h0010);
    wr(0, 6'h06, 16'h0010, 16'h0000);
    frame(8'h04, 1'b1);
    wr(0, 6'h06, 16'h0010, 16'h0010);
    rd(0, 6'h06, 16'h0011, 16'h0000);
    loop <= 1'b1;
    e = 1'($urandom);
    p = 1'($urandom);
    f0 = frames;
    wr(0, 6'h06, 16'h0010, {8'h02, 3'h0, 2'h3, p, 1'b0, e});
    repeat (300) @(posedge clk);
    check(16'(frames - f0), 16'h0002);
    rd(0, 6'h06, 16'h0011, {8'h02, e ? 8'h02 : 8'h00});
    f0 = frames;
    wr(0, 6'h06, 16'h0010, {8'h01, 3'h0, 2'h3, !p, 1'b1, !e});
    repeat (1700) @(posedge clk);
    check(16'(frames - f0), 16'h0001);
    f0 = frames;
    wr(0, 6'h06, 16'h0010, {8'h00, 3'h0, 2'h3, p, 2'h0});
    repeat (400) @(posedge clk);
    check(16'(frames - f0 > 3), 16'h0001);
    wr(0, 6'h06, 16'h0010, 16'h0010);
    // The cut frame ends late; let its count settle before the snapshot
    repeat (2) @(posedge clk);
    f0 = frames;
    repeat (200) @(posedge clk);
    check(16'(frames - f0), 16'h0000);
    higherPortTclk <= 1'($urandom);
    wr(0, 6'h06, 16'h001a, 16'hffff);
    rd(0, 6'h06, 16'h001a, 16'hffa0);
    check(transmitClockTestOutputEnable_ff, 16'h0001);
    check(differentialTestClockPinDrive_ff, 16'(!higherPortTclk));
    swRst <= 1'b1;
    @(posedge clk);
    swRst <= 1'b0;
    repeat (2) @(posedge clk);
    rd(0, 6'h06, 16'h001a, 16'h7fa0);
    check(transmitClockTestOutputEnable_ff, 16'h0000);
    wr(0, 6'h06, 16'h0012, 16'h0008);
    rd(0, 6'h06, 16'h0012, 16'h0008);
    check(stubTestEnable_ff, 16'h0001);
    wr(1, 6'h00, 16'h0000, 16'hffff);
    rd(1, 6'h00, 16'h0000, 16'h0400);
    check(clockStoppable_ff, 16'h0001);
    end_of_test;
  end
  initial begin
    #(20 * 40000);
    error_cnt++;
    end_of_test;
  end
endmodule // ptd_packet_test_bench
